// ===== pkg/mbs_defs.svh
// Constants of the serial register-protocol frame handler
`ifndef MBS_DEFS_SVH
`define MBS_DEFS_SVH
`define MBS_FC_RD_HOLD 8'h03
`define MBS_FC_WR_COIL 8'h05
`define MBS_FC_WR_MULTI 8'h10
`define MBS_FC_REP_ID 8'h11
`define MBS_CRC_INIT 16'hFFFF
`define MBS_CRC_POLY 16'hA001
`define MBS_RX_DEPTH 25
`define MBS_RX_CNT_MAX 5'h1F
`define MBS_NUM_HREG 16
`define MBS_HREG_LIMIT 17'h00010
`define MBS_MAX_RD 16'h0010
`define MBS_MAX_WR 16'h0008
`define MBS_REG_FLOW_LO 4'h6
`define MBS_REG_FLOW_HI 4'h7
`define MBS_REG_CONS_LO 4'h8
`define MBS_REG_CONS_HI 4'h9
`define MBS_LEN_RD_REQ 5'h08
`define MBS_LEN_COIL_REQ 5'h08
`define MBS_LEN_ID_REQ 5'h04
`define MBS_WR_HDR 5'h09
`define MBS_ECHO_LEN 6'h06
`define MBS_RD_RSP_HDR 6'h03
`define MBS_ID_RSP_LEN 6'h1D
`define MBS_ID_BYTE_CNT 8'h1A
`define MBS_ID_NAME_OFS 6'h09
`define MBS_COIL_ON 16'hFF00
`define MBS_COIL_OFF 16'h0000
`define MBS_ERR_NONE 8'h00
`define MBS_ERR_RTC 8'h01
`define MBS_ERR_ADC 8'h02
`define MBS_ERR_CFG 8'h04
`define MBS_ERR_FLASH 8'h08
`define MBS_ERR_FLOW 8'h20
`define MBS_ERR_TEMP 8'h30
`define MBS_ERR_RADIO 8'h40
`define MBS_NUM_FAULT 7
`endif

// ===== pkg/mbs_pkg.sv
// Types of the serial register-protocol frame handler
`default_nettype none
package mbs_pkg;
	// Received byte with end-of-frame marker
	typedef struct packed {
		logic valid;
		logic eof;
		logic [7:0] data;
	} mbs_rx_s;
	// Transmitted byte
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} mbs_tx_s;
	// Fault sources: rtc, adc, cfg, flash, flow, temp, radio (bit 0 up)
	typedef logic [6:0] mbs_fault_t;
	typedef enum logic [0:0] {ST_IDLE, ST_SEND} mbs_state_e;
endpackage
`default_nettype wire

// ===== rtl/mbs_slave.sv
// Frame handler: parses requests, builds replies, encodes fault codes
`include "mbs_defs.svh"
`default_nettype none
module mbs_slave #(
	parameter logic [15:0] SLAVE_ID = 16'h0001, // Arbitrary value
	parameter logic [15:0] RUN_IND = 16'h00FF,
	parameter logic [15:0] PRODUCT_CODE = 16'h1234, // Arbitrary value
	parameter logic [159:0] PRODUCT_NAME = 160'h466C6F774D657465720000000000000000000000 // Arbitrary value
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Own address and measurements
	input wire logic [7:0] i_dev_addr,
	input wire logic [31:0] i_flow,
	input wire logic [31:0] i_consumption,
	// Byte link
	input wire mbs_pkg::mbs_rx_s i_rx,
	input wire logic i_tx_ready,
	output mbs_pkg::mbs_tx_s o_tx,
	// Coils and faults
	output logic [15:0] o_coils,
	input wire mbs_pkg::mbs_fault_t i_fault,
	output logic [7:0] o_err_code
);
	mbs_pkg::mbs_state_e state_q;
	logic [7:0] rx_buf_q [0:`MBS_RX_DEPTH-1];
	logic [4:0] rx_cnt_q;
	logic [15:0] rx_crc_q;
	logic [15:0] hreg_q [0:`MBS_NUM_HREG-1];
	logic [5:0] tx_idx_q;
	logic [5:0] tx_len_q;
	logic [15:0] tx_crc_q;
	logic [7:0] fc;
	logic [15:0] start, qty;
	logic [16:0] span;
	logic rd_ok, coil_ok, wr_ok, id_ok, accept, load;
	logic [7:0] pay_byte;
	logic [5:0] off;
	logic [3:0] widx;
	logic [15:0] word;
	logic [5:0] nofs;
	// Assertion clock and reset
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	// Modbus CRC-16 byte step
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int k = 0; k < 8; k++) begin
			r = r[0] ? ((r >> 1) ^ `MBS_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// Request field decode
	assign fc = rx_buf_q[1];
	assign start = {rx_buf_q[2], rx_buf_q[3]};
	assign qty = {rx_buf_q[4], rx_buf_q[5]};
	assign span = {1'b0, start} + {1'b0, qty};
	assign rd_ok = fc == `MBS_FC_RD_HOLD && rx_cnt_q == `MBS_LEN_RD_REQ && qty != 16'h0000
		&& qty <= `MBS_MAX_RD && span <= `MBS_HREG_LIMIT;
	assign coil_ok = fc == `MBS_FC_WR_COIL && rx_cnt_q == `MBS_LEN_COIL_REQ && start < 16'h0010
		&& (qty == `MBS_COIL_ON || qty == `MBS_COIL_OFF);
	assign wr_ok = fc == `MBS_FC_WR_MULTI && qty != 16'h0000 && qty <= `MBS_MAX_WR
		&& rx_buf_q[6] == {qty[6:0], 1'b0} && rx_cnt_q == `MBS_WR_HDR + {qty[3:0], 1'b0}
		&& span <= `MBS_HREG_LIMIT;
	assign id_ok = fc == `MBS_FC_REP_ID && rx_cnt_q == `MBS_LEN_ID_REQ;
	// Accept only own address with zero CRC residue
	assign accept = state_q == mbs_pkg::ST_IDLE && i_rx.eof && !i_rx.valid && rx_buf_q[0] == i_dev_addr
		&& rx_crc_q == 16'h0000 && (rd_ok || coil_ok || wr_ok || id_ok);

	// Receive buffer and running CRC, idle only
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			rx_cnt_q <= 5'h00;
			rx_crc_q <= `MBS_CRC_INIT;
		end else if (state_q != mbs_pkg::ST_IDLE || i_rx.eof) begin
			rx_cnt_q <= 5'h00;
			rx_crc_q <= `MBS_CRC_INIT;
		end else if (i_rx.valid) begin
			if (rx_cnt_q < 5'(`MBS_RX_DEPTH)) begin
				rx_buf_q[rx_cnt_q] <= i_rx.data;
			end
			if (rx_cnt_q != `MBS_RX_CNT_MAX) begin
				rx_cnt_q <= rx_cnt_q + 5'h01;
			end
			rx_crc_q <= crc_step(rx_crc_q, i_rx.data);
		end
	end

	// Holding registers, committed only after a good frame
	for (genvar j = 0; j < `MBS_NUM_HREG; j++) begin : g_hreg
		logic [4:0] rel;
		assign rel = 5'(j) - start[4:0];
		always_ff @(posedge i_sys_clk) begin
			if (i_rst) begin
				hreg_q[j] <= 16'h0000;
			end else if (accept && wr_ok && 17'(j) >= {1'b0, start} && 17'(j) < span) begin
				hreg_q[j] <= {rx_buf_q[7 + 2 * rel[2:0]], rx_buf_q[8 + 2 * rel[2:0]]};
			end
		end
	end

	// Coils
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_coils <= 16'h0000;
		end else if (accept && coil_ok) begin
			o_coils[start[3:0]] <= qty == `MBS_COIL_ON;
		end
	end

	// Reply byte selection
	assign off = tx_idx_q - `MBS_RD_RSP_HDR;
	assign widx = start[3:0] + off[4:1];
	assign nofs = tx_idx_q - `MBS_ID_NAME_OFS;
	always_comb begin
		unique case (widx)
			`MBS_REG_FLOW_LO: word = i_flow[15:0];
			`MBS_REG_FLOW_HI: word = i_flow[31:16];
			`MBS_REG_CONS_LO: word = i_consumption[15:0];
			`MBS_REG_CONS_HI: word = i_consumption[31:16];
			default: word = hreg_q[widx];
		endcase
		pay_byte = rx_buf_q[tx_idx_q[2:0]];
		if (fc == `MBS_FC_RD_HOLD && tx_idx_q == 6'h02) begin
			pay_byte = {qty[6:0], 1'b0};
		end else if (fc == `MBS_FC_RD_HOLD && tx_idx_q > 6'h02) begin
			pay_byte = off[0] ? word[7:0] : word[15:8];
		end else if (fc == `MBS_FC_REP_ID && tx_idx_q > 6'h01) begin
			unique case (tx_idx_q)
				6'h02: pay_byte = `MBS_ID_BYTE_CNT;
				6'h03: pay_byte = SLAVE_ID[15:8];
				6'h04: pay_byte = SLAVE_ID[7:0];
				6'h05: pay_byte = RUN_IND[15:8];
				6'h06: pay_byte = RUN_IND[7:0];
				6'h07: pay_byte = PRODUCT_CODE[15:8];
				6'h08: pay_byte = PRODUCT_CODE[7:0];
				default: pay_byte = PRODUCT_NAME[8'(159 - 8 * nofs) -: 8];
			endcase
		end
	end

	assign load = state_q == mbs_pkg::ST_SEND && (!o_tx.valid || i_tx_ready);

	// Frame state and reply length
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state_q <= mbs_pkg::ST_IDLE;
			tx_len_q <= 6'h00;
		end else if (accept) begin
			state_q <= mbs_pkg::ST_SEND;
			if (rd_ok) begin
				tx_len_q <= `MBS_RD_RSP_HDR + {qty[4:0], 1'b0};
			end else if (id_ok) begin
				tx_len_q <= `MBS_ID_RSP_LEN;
			end else begin
				tx_len_q <= `MBS_ECHO_LEN;
			end
		end else if (load && tx_idx_q == tx_len_q + 6'h02) begin
			state_q <= mbs_pkg::ST_IDLE;
		end
	end

	// Transmit byte register and CRC
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_tx <= '0;
			tx_idx_q <= 6'h00;
			tx_crc_q <= `MBS_CRC_INIT;
		end else if (accept) begin
			tx_idx_q <= 6'h00;
			tx_crc_q <= `MBS_CRC_INIT;
		end else if (load) begin
			tx_idx_q <= tx_idx_q + 6'h01;
			if (tx_idx_q < tx_len_q) begin
				o_tx <= {1'b1, pay_byte};
				tx_crc_q <= crc_step(tx_crc_q, pay_byte);
			end else if (tx_idx_q == tx_len_q) begin
				o_tx <= {1'b1, tx_crc_q[7:0]};
			end else if (tx_idx_q == tx_len_q + 6'h01) begin
				o_tx <= {1'b1, tx_crc_q[15:8]};
			end else begin
				o_tx <= '0;
			end
		end
	end

	// Fault pin synchronisers; accepted once stages two and three agree
	mbs_pkg::mbs_fault_t flt_q;
	for (genvar f = 0; f < `MBS_NUM_FAULT; f++) begin : g_flt
		logic s1_q, s2_q, s3_q;
		always_ff @(posedge i_sys_clk) begin
			if (i_rst) begin
				s1_q <= 1'b0;
				s2_q <= 1'b0;
				s3_q <= 1'b0;
				flt_q[f] <= 1'b0;
			end else begin
				s1_q <= i_fault[f];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (s2_q == s3_q) begin
					flt_q[f] <= s3_q;
				end
			end
		end
	end

	// Fault code, first listed source wins
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_err_code <= `MBS_ERR_NONE;
		end else if (flt_q[0]) begin
			o_err_code <= `MBS_ERR_RTC;
		end else if (flt_q[1]) begin
			o_err_code <= `MBS_ERR_ADC;
		end else if (flt_q[2]) begin
			o_err_code <= `MBS_ERR_CFG;
		end else if (flt_q[3]) begin
			o_err_code <= `MBS_ERR_FLASH;
		end else if (flt_q[4]) begin
			o_err_code <= `MBS_ERR_FLOW;
		end else if (flt_q[5]) begin
			o_err_code <= `MBS_ERR_TEMP;
		end else if (flt_q[6]) begin
			o_err_code <= `MBS_ERR_RADIO;
		end else begin
			o_err_code <= `MBS_ERR_NONE;
		end
	end

	// Checks
	sequence s_accept_fc(logic [7:0] f);
		accept && fc == f;
	endsequence
	sequence s_load_at(logic [5:0] i);
		load && tx_idx_q == i && tx_idx_q < tx_len_q;
	endsequence
	AST_RD_REQ_LEN: assert property (state_q == mbs_pkg::ST_IDLE && i_rx.eof && fc == `MBS_FC_RD_HOLD
		&& rx_cnt_q != `MBS_LEN_RD_REQ |=> state_q == mbs_pkg::ST_IDLE)
		else $error("read with wrong length answered");
	AST_RD_BYTE_CNT: assert property (fc == `MBS_FC_RD_HOLD and s_load_at(6'h02) |=>
		o_tx.valid && o_tx.data == {$past(qty[6:0]), 1'b0}) else $error("read byte count wrong");
	AST_COIL_SET: assert property (s_accept_fc(`MBS_FC_WR_COIL) and qty == `MBS_COIL_ON |=>
		o_coils[$past(start[3:0])] && tx_len_q == 6'h06) else $error("coil not set");
	AST_WR_RSP_LEN: assert property (s_accept_fc(`MBS_FC_WR_MULTI) |=> tx_len_q == 6'h06 ##1 o_tx.valid)
		else $error("write reply length wrong");
	AST_ID_BYTE_CNT: assert property (fc == `MBS_FC_REP_ID and s_load_at(6'h02) |=> o_tx.data == 8'h1A)
		else $error("id byte count wrong");
	AST_ERR_RTC: assert property ((i_fault == 7'h01)[*6] |=> o_err_code == 8'h01)
		else $error("rtc fault code wrong");
	AST_ERR_RADIO: assert property ((i_fault == 7'h40)[*6] |=> o_err_code == 8'h40)
		else $error("radio fault code wrong");
	AST_MID_LE: assert property (fc == `MBS_FC_RD_HOLD && start == 16'h0006 and s_load_at(6'h03) |=>
		o_tx.data == $past(i_flow[15:8])) else $error("flow low word not first");
	AST_OWN_ADDR: assert property (accept |=> state_q == mbs_pkg::ST_SEND ##1 o_tx.valid
		&& o_tx.data == i_dev_addr) else $error("reply address wrong");
	AST_BAD_CRC: assert property (state_q == mbs_pkg::ST_IDLE && i_rx.eof && rx_crc_q != 16'h0000 |=>
		state_q == mbs_pkg::ST_IDLE) else $error("bad crc answered");
	AST_CRC_LOW_FIRST: assert property (load && tx_idx_q == tx_len_q |=>
		o_tx.data == $past(tx_crc_q[7:0])) else $error("crc low byte not first");
endmodule
`default_nettype wire

// ===== testbench/mbs_master_model.sv
// Bus master model: sends request frames and collects reply bytes
`default_nettype none
module mbs_master_model (
	input wire logic i_clk,
	input wire mbs_pkg::mbs_tx_s i_tx,
	input wire logic i_slow,
	output var mbs_pkg::mbs_rx_s o_rx,
	output var logic o_tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rsp[$];

	// Frame check sequence, reflected polynomial
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c ^= {8'h00, b[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		return c;
	endfunction

	// One byte per cycle, then the end-of-frame pulse
	task automatic send(input logic [7:0] f[$], input bit bad);
		logic [15:0] c;
		c = crc16(f) ^ {15'h0000, bad};
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		foreach (f[i]) begin
			@(posedge i_clk);
			o_rx <= '{1'b1, 1'b0, f[i]};
		end
		@(posedge i_clk);
		o_rx <= '{1'b0, 1'b1, ~f[f.size() - 1]};
		@(posedge i_clk);
		o_rx <= '{1'b0, 1'b0, f[0]};
	endtask

	initial begin
		o_rx = '0;
		o_tx_ready = 1'b0;
	end

	// Takes reply bytes; stalls every other cycle when slow
	always @(posedge i_clk) begin
		if (i_tx.valid === 1'b1 && o_tx_ready) rsp.push_back(i_tx.data);
		o_tx_ready <= !i_slow || !o_tx_ready;
	end
endmodule
`default_nettype wire

// ===== testbench/mbs_slave_test.sv
// Self-checking bench for the frame handler
`default_nettype none
module mbs_slave_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [159:0] NAME = 160'h0102030405060708090A0B0C0D0E0F1011121314;
	logic clk, rst, slow;
	logic [7:0] dev, err;
	logic [31:0] flow, cons;
	logic [15:0] coils, exp_coils;
	mbs_pkg::mbs_rx_s rx;
	mbs_pkg::mbs_tx_s tx;
	mbs_pkg::mbs_fault_t fault;
	logic rdy;
	int seed = 32'hD6E2;
	int n_errors = 0;
	int n_tests = 0;

	mbs_slave #(.PRODUCT_NAME(NAME)) dut_u (.i_sys_clk(clk), .i_rst(rst), .i_dev_addr(dev), .i_flow(flow),
		.i_consumption(cons), .i_rx(rx), .i_tx_ready(rdy), .o_tx(tx), .o_coils(coils), .i_fault(fault),
		.o_err_code(err));
	mbs_master_model m_u (.i_clk(clk), .i_tx(tx), .i_slow(slow), .o_rx(rx), .o_tx_ready(rdy));

	// Clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Request and reply; an empty reply means none expected
	task automatic xact(input logic [7:0] req[$], input logic [7:0] exp[$], input bit bad);
		logic [15:0] c;
		int t;
		m_u.rsp.delete();
		if (exp.size() > 0) begin
			c = m_u.crc16(exp);
			exp.push_back(c[7:0]);
			exp.push_back(c[15:8]);
		end
		m_u.send(req, bad);
		for (t = 0; t < 400 && m_u.rsp.size() <= exp.size(); t++) @(posedge clk);
		check(16'(m_u.rsp.size()), 16'(exp.size()));
		foreach (exp[i]) if (i < m_u.rsp.size()) check(m_u.rsp[i], exp[i]);
	endtask

	// Watchdog
	initial begin
		repeat (50000) @(posedge clk);
		n_errors++;
		final_report();
	end

	// Main sequence
	initial begin
		logic [7:0] q[$];
		logic [7:0] e[$];
		logic [15:0] w[8];
		logic [7:0] codes[9];
		logic [7:0] c;
		int k;
		codes = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h30, 8'h40, 8'h00, 8'h04};
		rst = 1'b1;
		slow = 1'b0;
		fault = '0;
		exp_coils = 16'h0000;
		dev = 8'h01 + 8'($random(seed) & 32'h7F);
		flow = $random(seed);
		cons = $random(seed);
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		q = '{dev, 8'h03, 8'h00, 8'h06, 8'h00, 8'h04};
		e = '{dev, 8'h03, 8'h08, flow[15:8], flow[7:0], flow[31:24], flow[23:16], cons[15:8], cons[7:0],
			cons[31:24], cons[23:16]};
		xact(q, e, 1'b0);
		q = '{dev, 8'h10, 8'h00, 8'h00, 8'h00, 8'h08, 8'h10};
		for (k = 0; k < 8; k++) begin
			w[k] = 16'($random(seed));
			q.push_back(w[k][15:8]);
			q.push_back(w[k][7:0]);
		end
		xact(q, q[0:5], 1'b0);
		slow <= 1'b1;
		q = '{dev, 8'h03, 8'h00, 8'h00, 8'h00, 8'h08};
		e = '{dev, 8'h03, 8'h10};
		for (k = 0; k < 8; k++) begin
			w[k] = (k == 6) ? flow[15:0] : (k == 7) ? flow[31:16] : w[k]; // Registers 6 and 7 read live flow
			e.push_back(w[k][15:8]);
			e.push_back(w[k][7:0]);
		end
		xact(q, e, 1'b0);
		slow <= 1'b0;
		for (k = 0; k < 6; k++) begin
			c = 8'($random(seed)) & 8'h0F;
			q = '{dev, 8'h05, 8'h00, c, k[0] ? 8'hFF : 8'h00, 8'h00};
			exp_coils[c[3:0]] = k[0];
			xact(q, q, 1'b0);
			check(coils, exp_coils);
		end
		q = '{dev, 8'h11};
		e = '{dev, 8'h11, 8'h1A, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h12, 8'h34};
		for (k = 0; k < 20; k++) e.push_back(NAME[159 - 8 * k -: 8]);
		xact(q, e, 1'b0);
		q = '{dev ^ 8'h01, 8'h03, 8'h00, 8'h06, 8'h00, 8'h02};
		e = {};
		xact(q, e, 1'b0);
		q[0] = dev;
		xact(q, e, 1'b1);
		q.push_back(8'h00);
		xact(q, e, 1'b0);
		for (k = 0; k < 9; k++) begin
			fault <= (k == 8) ? 7'h1C : 7'(1 << k);
			repeat (14) @(posedge clk);
			check(err, codes[k]);
		end
		final_report();
	end
endmodule
`default_nettype wire
